// ===== hw/move_core_pkg.sv
// constants, types and helper arithmetic shared by the move decoder and its pointer unit
// assumes one clock and a synchronous active-high reset in every user
package move_core_pkg;
	localparam int INSTR_W = 16;
	localparam int DATA_W = 16;
	localparam int FMT_BIT = 15;
	localparam int SRC_MOD_LSB = 0;
	localparam int SRC_IDX_LSB = 4;
	localparam int DST_MOD_LSB = 8;
	localparam int DST_IDX_LSB = 12;
	localparam logic [3:0] MEM_MOD = 4'he;
	localparam logic [3:0] PTR_MOD = 4'hf;
	// register indices inside the pointer module
	localparam logic [4:0] IDX_DP0 = 5'h00;
	localparam logic [4:0] IDX_DP1 = 5'h01;
	localparam logic [4:0] IDX_BASE = 5'h02;
	localparam logic [4:0] IDX_FRAME_OFFSET = 5'h03;
	localparam logic [4:0] IDX_SP = 5'h04;
	localparam logic [4:0] IDX_CP = 5'h05;
	localparam logic [4:0] IDX_PREFIX = 5'h07;
	// memory module: indices up to this one are data memory ports
	localparam logic [3:0] MEM_LAST_DATA = 4'h5;
	localparam logic [3:0] MEM_LAST_PORT = 4'h7;
	localparam logic [7:0] PREFIX_RESET = 8'h00;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [7:0] FRAME_OFFSET_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [15:0] ZERO_WORD = 16'h0000;

	typedef enum logic [1:0] {SEL_DP0, SEL_DP1, SEL_FP, SEL_CP} ptr_sel_type;

	function automatic logic [15:0] step16(input logic [15:0] v, input logic dec);
		return dec ? v - 16'h0001 : v + 16'h0001;
	endfunction

	function automatic logic [7:0] step8(input logic [7:0] v, input logic dec);
		return dec ? v - 8'h01 : v + 8'h01;
	endfunction
endpackage

// ===== hw/pointer_unit.sv
// data, frame, stack and code pointers with step logic for all but the stack pointer
// assumes write-stage effects and read-stage steps are requested in the same cycle
module pointer_unit (
	input wire logic clk, // core clock
	input wire logic rst, // synchronous reset
	ptr_if.unit p // requests from the decoder
);
	import move_core_pkg::*;
	logic [15:0] dp0_q, dp0_d, dp1_q, dp1_d, bp_q, bp_d, sp_q, sp_d, cp_q, cp_d;
	logic [7:0] frame_offset_q, frame_offset_d;

	// write-stage effects first, so the read stage sees them without a hazard
	always_comb begin
		dp0_d = dp0_q;
		dp1_d = dp1_q;
		bp_d = bp_q;
		frame_offset_d = frame_offset_q;
		sp_d = sp_q;
		cp_d = cp_q;
		p.wr_addr = ZERO_WORD;
		p.rd_addr = ZERO_WORD;
		if (p.wr_en) begin
			case (p.wr_sel)
				IDX_DP0[2:0]: dp0_d = p.wr_data;
				IDX_DP1[2:0]: dp1_d = p.wr_data;
				IDX_BASE[2:0]: bp_d = p.wr_data;
				IDX_FRAME_OFFSET[2:0]: frame_offset_d = p.wr_data[7:0];
				IDX_SP[2:0]: sp_d = p.wr_data;
				IDX_CP[2:0]: cp_d = p.wr_data;
				default: ;
			endcase
		end
		if (p.pre_en) begin
			case (p.pre_sel)
				SEL_DP0: begin
					dp0_d = step16(dp0_d, p.pre_dec);
					p.wr_addr = dp0_d;
				end
				SEL_DP1: begin
					dp1_d = step16(dp1_d, p.pre_dec);
					p.wr_addr = dp1_d;
				end
				default: begin
					frame_offset_d = step8(frame_offset_d, p.pre_dec);
					p.wr_addr = bp_d + {ZERO_BYTE, frame_offset_d};
				end
			endcase
		end
		if (p.post_en) begin
			case (p.post_sel)
				SEL_DP0: begin
					p.rd_addr = dp0_d;
					dp0_d = step16(dp0_d, p.post_dec);
				end
				SEL_DP1: begin
					p.rd_addr = dp1_d;
					dp1_d = step16(dp1_d, p.post_dec);
				end
				SEL_FP: begin
					p.rd_addr = bp_d + {ZERO_BYTE, frame_offset_d};
					frame_offset_d = step8(frame_offset_d, p.post_dec);
				end
				default: begin
					p.rd_addr = cp_d;
					cp_d = step16(cp_d, p.post_dec);
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dp0_q <= PTR_RESET;
			dp1_q <= PTR_RESET;
			bp_q <= PTR_RESET;
			frame_offset_q <= FRAME_OFFSET_RESET;
			sp_q <= PTR_RESET;
			cp_q <= PTR_RESET;
		end else begin
			dp0_q <= dp0_d;
			dp1_q <= dp1_d;
			bp_q <= bp_d;
			frame_offset_q <= frame_offset_d;
			sp_q <= sp_d;
			cp_q <= cp_d;
		end
	end

	assign p.dp0 = dp0_q;
	assign p.dp1 = dp1_q;
	assign p.bp = bp_q;
	assign p.frame_offset = frame_offset_q;
	assign p.sp = sp_q;
	assign p.cp = cp_q;

	property p_fp_base_kept;
		@(posedge clk) disable iff (rst)
		(p.post_en && p.post_sel == SEL_FP && !p.wr_en) |=> (bp_q == $past(bp_q));
	endproperty
	a_fp_base_kept: assert property (p_fp_base_kept) else $error("frame step changed base");

	property p_dp1_post_step;
		@(posedge clk) disable iff (rst)
		(p.post_en && p.post_sel == SEL_DP1 && !p.post_dec && !p.wr_en && !p.pre_en)
			|=> (dp1_q == $past(dp1_q) + 16'h0001);
	endproperty
	a_dp1_post_step: assert property (p_dp1_post_step) else $error("pointer did not step after read");
endmodule

// ===== hw/ptr_if.sv
// signals between the move decoder and its pointer unit
// assumes both ends share the core clock
interface ptr_if;
	import move_core_pkg::*;
	logic wr_en;
	logic [2:0] wr_sel;
	logic [15:0] wr_data;
	logic pre_en;
	logic pre_dec;
	ptr_sel_type pre_sel;
	logic post_en;
	logic post_dec;
	ptr_sel_type post_sel;
	logic [15:0] wr_addr;
	logic [15:0] rd_addr;
	logic [15:0] dp0;
	logic [15:0] dp1;
	logic [15:0] bp;
	logic [7:0] frame_offset;
	logic [15:0] sp;
	logic [15:0] cp;
	modport core (output wr_en, wr_sel, wr_data, pre_en, pre_dec, pre_sel, post_en, post_dec, post_sel,
		input wr_addr, rd_addr, dp0, dp1, bp, frame_offset, sp, cp);
	modport unit (input wr_en, wr_sel, wr_data, pre_en, pre_dec, pre_sel, post_en, post_dec, post_sel,
		output wr_addr, rd_addr, dp0, dp1, bp, frame_offset, sp, cp);
endinterface

// ===== hw/transport_move_decoder.sv
// two-stage move decoder: read stage issues source accesses, write stage delivers the value
// assumes register modules answer a source read combinationally in the same cycle as SRC_RD,
// and both memories return read data in the same cycle as their read strobe
module transport_move_decoder (
	input wire logic CORE_CLK, // core clock
	input wire logic RESET, // synchronous reset
	input wire logic [move_core_pkg::INSTR_W-1:0] INSTR, // instruction word
	input wire logic INSTR_VALID, // instruction present this cycle
	input wire logic [move_core_pkg::DATA_W-1:0] SRC_DATA, // external source value
	input wire logic SRC_DEFINED, // external source location exists
	input wire logic SRC_WIDE, // external source is 16-bit
	input wire logic SRC_MOD_WIDE, // source module has only 16-bit registers
	input wire logic [move_core_pkg::DATA_W-1:0] DMEM_RDATA, // data memory read data
	input wire logic [move_core_pkg::DATA_W-1:0] PMEM_RDATA, // program memory read data
	output logic SRC_RD, // external source read strobe
	output logic [3:0] SRC_MOD, // source module
	output logic [3:0] SRC_IDX, // source register
	output logic DST_WR, // external destination write strobe
	output logic [3:0] DST_MOD, // destination module
	output logic [4:0] DST_IDX, // destination register, prefix extended
	output logic [move_core_pkg::DATA_W-1:0] DST_DATA, // destination value
	output logic DMEM_RD, // data memory read strobe
	output logic [15:0] DMEM_RADDR, // data memory read address
	output logic DMEM_WR, // data memory write strobe
	output logic [15:0] DMEM_WADDR, // data memory write address
	output logic [move_core_pkg::DATA_W-1:0] DMEM_WDATA, // data memory write data
	output logic PMEM_RD, // program memory read strobe
	output logic [15:0] PMEM_RADDR // program memory read address
);
	import move_core_pkg::*;

	ptr_if p ();

	pointer_unit u_ptr (
		.clk(CORE_CLK),
		.rst(RESET),
		.p(p.unit)
	);

	// ----------------------------------------
	// read stage
	// ----------------------------------------
	logic s2_valid_q, s2_valid_d;
	logic [15:0] ins_q, ins_d;
	logic src_rd_q, src_rd_d, dmem_rd_q, dmem_rd_d, pmem_rd_q, pmem_rd_d;
	logic [3:0] src_mod_q, src_mod_d, src_idx_q, src_idx_d;
	logic [15:0] draddr_q, draddr_d, praddr_q, praddr_d;
	logic [3:0] rmod, ridx;

	// one whole word per instruction, so each accepted word is a complete move
	always_comb begin
		rmod = INSTR[SRC_MOD_LSB +: 4];
		ridx = INSTR[SRC_IDX_LSB +: 4];
		s2_valid_d = INSTR_VALID;
		ins_d = INSTR_VALID ? INSTR : ins_q;
		src_rd_d = 1'b0;
		dmem_rd_d = 1'b0;
		pmem_rd_d = 1'b0;
		src_mod_d = src_mod_q;
		src_idx_d = src_idx_q;
		draddr_d = draddr_q;
		praddr_d = praddr_q;
		p.post_en = 1'b0;
		p.post_dec = ridx[0];
		p.post_sel = ptr_sel_type'(ridx[2:1]);
		if (INSTR_VALID && INSTR[FMT_BIT]) begin
			if (rmod == MEM_MOD) begin
				if (ridx <= MEM_LAST_PORT) begin
					p.post_en = 1'b1;
					if (ridx > MEM_LAST_DATA) begin
						pmem_rd_d = 1'b1;
						praddr_d = p.rd_addr;
					end else begin
						dmem_rd_d = 1'b1;
						draddr_d = p.rd_addr;
					end
				end
			end else if (rmod != PTR_MOD) begin
				src_rd_d = 1'b1;
				src_mod_d = rmod;
				src_idx_d = ridx;
			end
		end
	end

	// read stage registers
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			s2_valid_q <= 1'b0;
			ins_q <= ZERO_WORD;
			src_rd_q <= 1'b0;
			dmem_rd_q <= 1'b0;
			pmem_rd_q <= 1'b0;
			src_mod_q <= 4'h0;
			src_idx_q <= 4'h0;
			draddr_q <= ZERO_WORD;
			praddr_q <= ZERO_WORD;
		end else begin
			s2_valid_q <= s2_valid_d;
			ins_q <= ins_d;
			src_rd_q <= src_rd_d;
			dmem_rd_q <= dmem_rd_d;
			pmem_rd_q <= pmem_rd_d;
			src_mod_q <= src_mod_d;
			src_idx_q <= src_idx_d;
			draddr_q <= draddr_d;
			praddr_q <= praddr_d;
		end
	end

	// ----------------------------------------
	// write stage
	// ----------------------------------------
	logic [7:0] prefix_q, prefix_d;
	logic dst_wr_q, dst_wr_d, dmem_wr_q, dmem_wr_d;
	logic [3:0] dst_mod_q, dst_mod_d, smod, sidx, wmod;
	logic [4:0] dst_idx_q, dst_idx_d, widx;
	logic [15:0] dst_data_q, dst_data_d, waddr_q, waddr_d, wdata_q, wdata_d;
	logic [15:0] raw, value;
	logic narrow;

	// source value selection and width fitting
	always_comb begin
		smod = ins_q[SRC_MOD_LSB +: 4];
		sidx = ins_q[SRC_IDX_LSB +: 4];
		raw = {prefix_q, ZERO_BYTE};
		narrow = 1'b0;
		if (!ins_q[FMT_BIT]) begin
			raw = {ZERO_BYTE, ins_q[7:0]};
			narrow = 1'b1;
		end else if (smod == PTR_MOD) begin
			// mixed-width module reads prefix:00h when undefined
			case ({1'b0, sidx})
				IDX_DP0: raw = p.dp0;
				IDX_DP1: raw = p.dp1;
				IDX_BASE: raw = p.bp;
				IDX_SP: raw = p.sp;
				IDX_CP: raw = p.cp;
				IDX_FRAME_OFFSET: begin
					raw = {ZERO_BYTE, p.frame_offset};
					narrow = 1'b1;
				end
				IDX_PREFIX: begin
					raw = {ZERO_BYTE, prefix_q};
					narrow = 1'b1;
				end
				default: raw = {prefix_q, ZERO_BYTE};
			endcase
		end else if (smod == MEM_MOD) begin
			// 16-bit-only module reads zero when undefined
			if (sidx <= MEM_LAST_DATA)
				raw = DMEM_RDATA;
			else if (sidx <= MEM_LAST_PORT)
				raw = PMEM_RDATA;
			else
				raw = ZERO_WORD;
		end else if (SRC_DEFINED) begin
			raw = SRC_DATA;
			narrow = !SRC_WIDE;
		end else begin
			raw = SRC_MOD_WIDE ? ZERO_WORD : {prefix_q, ZERO_BYTE};
		end
		// narrow source takes prefix as high byte; narrow targets keep low byte
		value = narrow ? {prefix_q, raw[7:0]} : raw;
	end

	// destination decode; a move is any source into any destination
	always_comb begin
		wmod = ins_q[DST_MOD_LSB +: 4];
		// three instruction bits plus two prefix bits reach all 32
		widx = {prefix_q[1:0], ins_q[DST_IDX_LSB +: 3]};
		// prefix falls back to zero unless written now
		prefix_d = PREFIX_RESET;
		dst_wr_d = 1'b0;
		dmem_wr_d = 1'b0;
		dst_mod_d = dst_mod_q;
		dst_idx_d = dst_idx_q;
		dst_data_d = dst_data_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		p.wr_en = 1'b0;
		p.wr_sel = widx[2:0];
		p.wr_data = value;
		p.pre_en = 1'b0;
		p.pre_dec = widx[0];
		p.pre_sel = ptr_sel_type'(widx[2:1]);
		if (s2_valid_q) begin
			if (wmod == PTR_MOD) begin
				if (widx == IDX_PREFIX)
					prefix_d = value[7:0];
				else if (widx <= IDX_CP)
					p.wr_en = 1'b1;
			end else if (wmod == MEM_MOD) begin
				if (widx <= {1'b0, MEM_LAST_DATA}) begin
					p.pre_en = 1'b1;
					dmem_wr_d = 1'b1;
					waddr_d = p.wr_addr;
					wdata_d = value;
				end
			end else begin
				// external registers, including accumulator side effects
				dst_wr_d = 1'b1;
				dst_mod_d = wmod;
				dst_idx_d = widx;
				dst_data_d = value;
			end
		end
	end

	// write stage registers
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			prefix_q <= PREFIX_RESET;
			dst_wr_q <= 1'b0;
			dmem_wr_q <= 1'b0;
			dst_mod_q <= 4'h0;
			dst_idx_q <= 5'h00;
			dst_data_q <= ZERO_WORD;
			waddr_q <= ZERO_WORD;
			wdata_q <= ZERO_WORD;
		end else begin
			prefix_q <= prefix_d;
			dst_wr_q <= dst_wr_d;
			dmem_wr_q <= dmem_wr_d;
			dst_mod_q <= dst_mod_d;
			dst_idx_q <= dst_idx_d;
			dst_data_q <= dst_data_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
		end
	end

	// separate program and data ports, one move per cycle
	assign SRC_RD = src_rd_q;
	assign SRC_MOD = src_mod_q;
	assign SRC_IDX = src_idx_q;
	assign DMEM_RD = dmem_rd_q;
	assign DMEM_RADDR = draddr_q;
	assign PMEM_RD = pmem_rd_q;
	assign PMEM_RADDR = praddr_q;
	assign DST_WR = dst_wr_q;
	assign DST_MOD = dst_mod_q;
	assign DST_IDX = dst_idx_q;
	assign DST_DATA = dst_data_q;
	assign DMEM_WR = dmem_wr_q;
	assign DMEM_WADDR = waddr_q;
	assign DMEM_WDATA = wdata_q;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_reg_source;
		@(posedge CORE_CLK) disable iff (RESET)
		(INSTR_VALID && INSTR[15] && INSTR[3:0] < MEM_MOD)
			|=> (SRC_RD && SRC_MOD == $past(INSTR[3:0]) && SRC_IDX == $past(INSTR[7:4]));
	endproperty
	a_reg_source: assert property (p_reg_source) else $error("register source not issued");
	property p_imm_no_read;
		@(posedge CORE_CLK) disable iff (RESET)
		(INSTR_VALID && !INSTR[15]) |=> (!SRC_RD && !DMEM_RD && !PMEM_RD);
	endproperty
	a_imm_no_read: assert property (p_imm_no_read) else $error("literal move started a read");
	property p_imm_value;
		@(posedge CORE_CLK) disable iff (RESET)
		(INSTR_VALID && !INSTR[15] && INSTR[11:8] < MEM_MOD) |=> ##1
			(DST_WR && DST_DATA[7:0] == $past(INSTR[7:0], 2));
	endproperty
	a_imm_value: assert property (p_imm_value) else $error("literal byte lost");
	property p_dst_fields;
		@(posedge CORE_CLK) disable iff (RESET)
		(INSTR_VALID && INSTR[11:8] < MEM_MOD) |=> ##1
			(DST_MOD == $past(INSTR[11:8], 2) && DST_IDX[2:0] == $past(INSTR[14:12], 2));
	endproperty
	a_dst_fields: assert property (p_dst_fields) else $error("destination fields wrong");
	property p_prefix_ext;
		@(posedge CORE_CLK) disable iff (RESET)
		dst_wr_d |=> (DST_IDX[4:3] == $past(prefix_q[1:0]));
	endproperty
	a_prefix_ext: assert property (p_prefix_ext) else $error("prefix extension missing");
	property p_prefix_short;
		@(posedge CORE_CLK) disable iff (RESET)
		(prefix_q != PREFIX_RESET && !(s2_valid_q && wmod == PTR_MOD && widx == IDX_PREFIX))
			|=> (prefix_q == PREFIX_RESET);
	endproperty
	a_prefix_short: assert property (p_prefix_short) else $error("prefix held too long");
	property p_high_fill;
		@(posedge CORE_CLK) disable iff (RESET)
		(s2_valid_q && !ins_q[15] && ins_q[11:8] < MEM_MOD) |=> (DST_DATA[15:8] == $past(prefix_q));
	endproperty
	a_high_fill: assert property (p_high_fill) else $error("high byte not from prefix");
	property p_undef_wide;
		@(posedge CORE_CLK) disable iff (RESET)
		(s2_valid_q && ins_q[15] && ins_q[3:0] == MEM_MOD && ins_q[7] && ins_q[11:8] < MEM_MOD)
			|=> (DST_WR && DST_DATA == ZERO_WORD);
	endproperty
	a_undef_wide: assert property (p_undef_wide) else $error("undefined wide source not zero");
	property p_reset_prefix;
		@(posedge CORE_CLK) RESET |=> (prefix_q == PREFIX_RESET);
	endproperty
	a_reset_prefix: assert property (p_reset_prefix) else $error("prefix not cleared by reset");
endmodule

// ===== tb/far_side_model.sv
// far-side model: external register modules, data memory and program memory
// assumes strobes and addresses leave registers just after the rising edge
package far_side_pkg;
	localparam logic [3:0] HOLE_IDX = 4'hb; // index left undefined in every module
	localparam logic [3:0] WIDE_MOD = 4'hd; // module holding only 16-bit registers
	function automatic logic [15:0] reg_val(input logic [3:0] m, input logic [3:0] i);
		return {i, m, ~m, i ^ 4'h6};
	endfunction
	function automatic logic [15:0] mem_init(input logic [15:0] a);
		return a ^ 16'hc3a5;
	endfunction
	function automatic logic [15:0] prog_val(input logic [15:0] a);
		return ~a + 16'h1357;
	endfunction
endpackage

module far_side_model (
	input logic clk, // core clock
	input logic src_rd, // register read strobe
	input logic [3:0] src_mod, // source module
	input logic [3:0] src_idx, // source register
	input logic dmem_rd, // data read strobe
	input logic [15:0] dmem_raddr, // data read address
	input logic dmem_wr, // data write strobe
	input logic [15:0] dmem_waddr, // data write address
	input logic [15:0] dmem_wdata, // data write value
	input logic pmem_rd, // program read strobe
	input logic [15:0] pmem_raddr, // program read address
	output logic [15:0] src_data, // register value
	output logic src_defined, // location exists
	output logic src_wide, // register is 16-bit
	output logic src_mod_wide, // module is 16-bit only
	output logic [15:0] dmem_rdata, // data memory value
	output logic [15:0] pmem_rdata // program memory value
);
	timeunit 1ns;
	timeprecision 1ps;
	import far_side_pkg::*;
	logic [15:0] mem [logic [15:0]];
	logic s_q, d_q, p_q;
	logic [3:0] m_q, i_q, m, i;
	logic [15:0] da_q, pa_q;

	function automatic logic [15:0] mget(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : mem_init(a);
	endfunction

	initial begin
		{src_data, src_defined, src_wide, src_mod_wide, dmem_rdata, pmem_rdata} = 51'h0;
		{s_q, d_q, p_q, m_q, i_q, da_q, pa_q} = 43'h0;
	end

	// answers stand from the strobe cycle through the next edge; released lines flip every cycle
	always @(negedge clk) begin
		if (src_rd || s_q) begin
			m = src_rd ? src_mod : m_q;
			i = src_rd ? src_idx : i_q;
			src_data <= reg_val(m, i);
			src_defined <= i != HOLE_IDX;
			src_mod_wide <= m == WIDE_MOD;
			src_wide <= m[0];
		end else begin
			src_data <= ~src_data;
			src_defined <= ~src_defined;
			src_wide <= ~src_wide;
			src_mod_wide <= ~src_mod_wide;
		end
		dmem_rdata <= dmem_rd ? mget(dmem_raddr) : d_q ? mget(da_q) : ~dmem_rdata;
		pmem_rdata <= pmem_rd ? prog_val(pmem_raddr) : p_q ? prog_val(pa_q) : ~pmem_rdata;
	end

	// remember the last request for the hold cycle; a write lands at the edge ending its strobe
	always @(posedge clk) begin
		{s_q, m_q, i_q} <= {src_rd, src_mod, src_idx};
		{d_q, da_q} <= {dmem_rd, dmem_raddr};
		{p_q, pa_q} <= {pmem_rd, pmem_raddr};
		if (dmem_wr)
			mem[dmem_waddr] = dmem_wdata;
	end
endmodule

// ===== tb/transport_move_decoder_tb.sv
// self-checking bench for the move decoder: corner words, random words, a mid-run reset
// assumes the far-side model file is compiled before this one
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module transport_move_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import far_side_pkg::*;
	typedef struct packed {
		logic srd, drd, prd, dwr, mwr;
		logic [3:0] smod, sidx, dmod;
		logic [4:0] didx;
		logic [15:0] raddr, paddr, ddata, waddr, wdata;
	} exp_type;
	logic clk, rst, valid, run, sdef, swide, smw, srd, dwr, drd, dmwr, prd;
	logic [15:0] instr, sdata, drdata, prdata, ddata_o, rdaddr, wraddr, wdata_o, paddr_o;
	logic [3:0] smod, sidx, dmod;
	logic [4:0] didx;
	exp_type er, ew, pw;
	logic [7:0] pfx, frame_offset;
	logic [15:0] dp0, dp1, bp, sp, cp, w;
	logic [15:0] mm [logic [15:0]];
	int failures, checks, seed_v;
	int cycles = 0;
	// prefix write just before an upper destination; a gap drops it
	logic [16:0] corner [$] = {17'h18132, 17'h10103, 17'h17f12, 17'h181b1, 17'h17f03, 17'h17155,
		17'h181bd, 17'h17fab, 17'h07fab, 17'h10203, 17'h10f10, 17'h11f20, 17'h12f30, 17'h13f05,
		17'h15f40, 17'h1810e, 17'h1811e, 17'h10e55, 17'h11e66, 17'h12e77, 17'h13e88, 17'h14e99,
		17'h15eaa, 17'h1812e, 17'h1813e, 17'h1814e, 17'h1815e, 17'h1806e, 17'h1807e, 17'h1808e,
		17'h17f77, 17'h1806f, 17'h16e12, 17'h16f12, 17'h1ef32, 17'h18e0e, 17'h1800f, 17'h1803f,
		17'h17f5a, 17'h1807f, 17'h10203, 17'h1812e};

	transport_move_decoder dut_u (.CORE_CLK(clk), .RESET(rst), .INSTR(instr), .INSTR_VALID(valid),
		.SRC_DATA(sdata), .SRC_DEFINED(sdef), .SRC_WIDE(swide), .SRC_MOD_WIDE(smw), .DMEM_RDATA(drdata),
		.PMEM_RDATA(prdata), .SRC_RD(srd), .SRC_MOD(smod), .SRC_IDX(sidx), .DST_WR(dwr), .DST_MOD(dmod),
		.DST_IDX(didx), .DST_DATA(ddata_o), .DMEM_RD(drd), .DMEM_RADDR(rdaddr), .DMEM_WR(dmwr),
		.DMEM_WADDR(wraddr), .DMEM_WDATA(wdata_o), .PMEM_RD(prd), .PMEM_RADDR(paddr_o));
	far_side_model far_u (.clk(clk), .src_rd(srd), .src_mod(smod), .src_idx(sidx), .dmem_rd(drd),
		.dmem_raddr(rdaddr), .dmem_wr(dmwr), .dmem_waddr(wraddr), .dmem_wdata(wdata_o), .pmem_rd(prd),
		.pmem_raddr(paddr_o), .src_data(sdata), .src_defined(sdef), .src_wide(swide),
		.src_mod_wide(smw), .dmem_rdata(drdata), .pmem_rdata(prdata));

	function automatic logic [15:0] bump(input logic [15:0] x, input logic d);
		return x + (d ? 16'hffff : 16'h0001);
	endfunction

	function automatic logic [15:0] mget(input logic [15:0] a);
		return mm.exists(a) ? mm[a] : mem_init(a);
	endfunction

	// one whole move in order; forwarding in the core makes this match back-to-back issue
	task automatic model(input logic [15:0] w);
		logic [15:0] v, a;
		logic [3:0] sm, si;
		logic [4:0] di;
		logic [7:0] np;
		sm = w[3:0];
		si = w[7:4];
		di = {pfx[1:0], w[14:12]};
		np = 8'h00;
		v = 16'h0000;
		if (!w[15])
			v = {pfx, w[7:0]};
		else if (sm < 4'he) begin
			er.srd = 1'b1;
			er.smod = sm;
			er.sidx = si;
			a = reg_val(sm, si);
			if (si == HOLE_IDX)
				v = (sm == WIDE_MOD) ? 16'h0000 : {pfx, 8'h00};
			else
				v = sm[0] ? a : {pfx, a[7:0]};
		end else if (sm == 4'he) begin
			if (!si[3]) begin
				a = si[2] ? (si[1] ? cp : bp + {8'h00, frame_offset}) : (si[1] ? dp1 : dp0);
				er.prd = si[2] & si[1];
				er.drd = ~er.prd;
				er.paddr = a;
				er.raddr = a;
				v = er.prd ? prog_val(a) : mget(a);
				case (si[2:1])
					2'h0: dp0 = bump(dp0, si[0]);
					2'h1: dp1 = bump(dp1, si[0]);
					2'h2: frame_offset = frame_offset + (si[0] ? 8'hff : 8'h01);
					default: cp = bump(cp, si[0]);
				endcase
			end
		end else case (si)
			4'h0: v = dp0;
			4'h1: v = dp1;
			4'h2: v = bp;
			4'h3: v = {pfx, frame_offset};
			4'h4: v = sp;
			4'h5: v = cp;
			4'h7: v = {pfx, pfx};
			default: v = {pfx, 8'h00};
		endcase
		if (w[11:8] < 4'he) begin
			pw.dwr = 1'b1;
			pw.dmod = w[11:8];
			pw.didx = di;
			pw.ddata = v;
		end else if (w[11:8] == 4'he) begin
			if (di < 5'h06) begin
				case (di[2:1])
					2'h0: dp0 = bump(dp0, di[0]);
					2'h1: dp1 = bump(dp1, di[0]);
					default: frame_offset = frame_offset + (di[0] ? 8'hff : 8'h01);
				endcase
				pw.mwr = 1'b1;
				pw.waddr = di[2] ? bp + {8'h00, frame_offset} : di[1] ? dp1 : dp0;
				pw.wdata = v;
			end
		end else case (di)
			5'h00: dp0 = v;
			5'h01: dp1 = v;
			5'h02: bp = v;
			5'h03: frame_offset = v[7:0];
			5'h04: sp = v;
			5'h05: cp = v;
			5'h07: np = v[7:0];
			default: ;
		endcase
		pfx = np;
	endtask

	// reference pipeline: read-stage view for the next cycle, write-stage view one later
	always @(posedge clk) begin
		run <= 1'b1;
		if (ew.mwr)
			mm[ew.waddr] = ew.wdata;
		ew = pw;
		er = '0;
		pw = '0;
		if (rst) begin
			ew = '0;
			{pfx, frame_offset, dp0, dp1, bp, sp, cp} = 96'h0;
		end else if (!valid)
			pfx = 8'h00;
		else
			model(instr);
	end

	// outputs are settled by the falling edge
	always @(negedge clk) if (run) begin
		`CHK({srd, drd, prd}, {er.srd, er.drd, er.prd})
		`CHK({dwr, dmwr}, {ew.dwr, ew.mwr})
		if (er.srd) `CHK({smod, sidx}, {er.smod, er.sidx})
		if (er.drd) `CHK(rdaddr, er.raddr)
		if (er.prd) `CHK(paddr_o, er.paddr)
		if (ew.dwr) `CHK({dmod, didx}, {ew.dmod, ew.didx})
		if (ew.dwr) `CHK(ddata_o, ew.ddata)
		if (ew.mwr) `CHK({wraddr, wdata_o}, {ew.waddr, ew.wdata})
	end

	task automatic send(input logic [16:0] e);
		@(negedge clk);
		valid = e[16];
		instr = e[15:0];
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		{rst, valid, instr, run, failures, checks} = {1'b1, 17'h0, 1'b0, 64'h0};
		{er, ew, pw} = '0;
		seed_v = $urandom(87407);
		repeat (8) @(negedge clk);
		rst = 1'b0;
		foreach (corner[k])
			send(corner[k]);
		$display("test corner words done");
		repeat (600) begin
			w = 16'($urandom);
			send({1'($urandom % 4 != 0), w});
		end
		$display("test random words done");
		send(17'h17fff);
		@(negedge clk);
		rst = 1'b1;
		valid = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		send(17'h10105);
		send(17'h00000);
		@(negedge clk);
		`CHK(ddata_o, 16'h0005)
		$display("test reset mid-run done");
		repeat (3) send(17'h00000);
		end_of_test();
	end
endmodule
